// [verilog/bsw_pkg.sv]
// constants of the four-channel bus switch control logic
// assumes a 20 MHz system clock and a two-wire upstream serial bus
package bsw_pkg;
    localparam int unsigned CLK_HZ         = 20000000;
    localparam int unsigned RESET_LOW_MIN_WIDTH_NS = 6;
    localparam int unsigned RESET_RELEASE_MAX_NS   = 500;
    localparam int unsigned HOLD_MIN_NS    = 300;
    // least hold time, rounded up to whole cycles
    localparam int unsigned HOLD_CYC =
        (HOLD_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [4:0] ADDR_FIXED      = 5'h0e;
    localparam int unsigned NUM_CHAN       = 4;
    localparam logic [7:0] SELECT_RESET    = 8'h00;
    typedef enum logic [2:0] {
        BSW_IDLE,
        BSW_ADDR,
        BSW_ACK,
        BSW_WRITE,
        BSW_READ,
        BSW_RACK,
        BSW_SKIP
    } bsw_state_t;
endpackage

// [verilog/bsw_switch_ctrl.sv]
// control logic of a four-channel two-wire bus switch
// assumes clk at 20 MHz; scl, sda and straps are asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module bsw_switch_ctrl #(
    parameter int unsigned HOLD_CYCLES = bsw_pkg::HOLD_CYC // hold window
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       addr_strap_bit_zero,
    input  wire logic       addr_strap_bit_one,
    input  wire logic       addr_strap_bit_two,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic [3:0]      channel_enable,
    output logic [7:0]      channel_select
);
    // two-stage synchronisers for the scl, sda and strap pins; rstn has none
    logic [1:0] scl_meta;         // first stage, read by second only
    logic [1:0] sda_meta;
    logic [2:0] strap_meta;
    logic       scl_s;            // synchronised clock line
    logic       sda_s;            // synchronised data line
    logic [2:0] strap_s;          // synchronised straps
    logic       scl_d;            // delayed for edge finding
    logic       sda_d;
    bsw_pkg::bsw_state_t state;   // protocol state
    logic [3:0] bitcnt;           // bit position within byte
    logic [7:0] shift;            // shift register
    logic [7:0] pend;             // written value awaiting stop
    logic       pend_valid;       // a write waits for stop
    logic       drive_low;        // wanted level on data line
    logic [4:0] hold_cnt;         // hold counter after clock fall
    logic       sda_out_q;

    // the hold counter is five bits wide and must run at least once
    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 31) begin : g_hold_range
        $error("hold window does not fit the counter");
    end

    // pin synchronisers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_meta   <= 2'h3;
            sda_meta   <= 2'h3;
            strap_meta <= 3'h0;
            strap_s    <= 3'h0;
        end else begin
            scl_meta   <= {scl_meta[0], scl_in};
            sda_meta   <= {sda_meta[0], sda_in};
            strap_meta <= {addr_strap_bit_two, addr_strap_bit_one,
                           addr_strap_bit_zero};
            strap_s    <= strap_meta;
        end
    end
    // only the second stages feed the protocol logic
    assign scl_s = scl_meta[1];
    assign sda_s = sda_meta[1];

    // edge and condition detection
    wire scl_rise  = scl_s & ~scl_d;
    wire scl_fall  = ~scl_s & scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
    wire [7:0] next_shift = {shift[6:0], sda_s};
    // address match: fixed upper bits plus straps
    // compared once all eight bits sit in the shift register
    wire addr_hit = (shift[7:1] == {bsw_pkg::ADDR_FIXED[3:0],
                     strap_s});
    wire hold_done = (hold_cnt == 5'h00);

    // delayed copies of the lines
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // protocol state machine; reset clears it and deselects
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state      <= bsw_pkg::BSW_IDLE;
            bitcnt     <= 4'h0;
            shift      <= 8'h00;
            pend       <= bsw_pkg::SELECT_RESET;
            pend_valid <= 1'b0;
            drive_low  <= 1'b0;
        end else if (start_det) begin
            // start or repeated start always begins an address
            state     <= bsw_pkg::BSW_ADDR;
            bitcnt    <= 4'h0;
            drive_low <= 1'b0;
        end else if (stop_det) begin
            state     <= bsw_pkg::BSW_IDLE;
            drive_low <= 1'b0;
            pend_valid <= 1'b0;
        end else begin
            case (state)
                bsw_pkg::BSW_ADDR: begin
                    // one address bit in on each rising clock
                    if (scl_rise) begin
                        shift  <= next_shift;
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        // eight bits in: ack only on a match
                        bitcnt <= 4'h0;
                        if (addr_hit) begin
                            drive_low <= 1'b1; // ack
                            state     <= bsw_pkg::BSW_ACK;
                        end else begin
                            state <= bsw_pkg::BSW_SKIP;
                        end
                    end
                end
                bsw_pkg::BSW_ACK: begin
                    // ack clock ends: pick direction from last bit
                    if (scl_fall) begin
                        if (shift[0]) begin
                            state     <= bsw_pkg::BSW_READ;
                            shift     <= channel_select;
                            drive_low <= ~channel_select[7];
                        end else begin
                            state     <= bsw_pkg::BSW_WRITE;
                            drive_low <= 1'b0;
                        end
                    end
                end
                bsw_pkg::BSW_WRITE: begin
                    if (scl_rise) begin
                        shift  <= next_shift;
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        // each full byte replaces the pending one
                        pend       <= shift;
                        pend_valid <= 1'b1;
                        drive_low  <= 1'b1;
                        bitcnt     <= 4'h0;
                        state      <= bsw_pkg::BSW_ACK;
                        shift      <= 8'h00;        // keep write path
                    end
                end
                bsw_pkg::BSW_READ: begin
                    // shift out on each fall, ack slot after eight
                    if (scl_fall) begin
                        if (bitcnt == 4'h7) begin
                            drive_low <= 1'b0;
                            bitcnt    <= 4'h0;
                            state     <= bsw_pkg::BSW_RACK;
                        end else begin
                            drive_low <= ~shift[6];
                            shift     <= {shift[6:0], 1'b0};
                            bitcnt    <= bitcnt + 4'h1;
                        end
                    end
                end
                bsw_pkg::BSW_RACK: begin
                    // controller ack on rise: send register again
                    if (scl_rise) begin
                        state <= sda_s ? bsw_pkg::BSW_SKIP
                                       : bsw_pkg::BSW_RACK;
                        shift <= channel_select;
                    end else if (scl_fall) begin
                        state     <= bsw_pkg::BSW_READ;
                        drive_low <= ~channel_select[7];
                    end
                end
                bsw_pkg::BSW_IDLE, bsw_pkg::BSW_SKIP: begin
                    drive_low <= 1'b0;
                end
                default: begin
                    state     <= bsw_pkg::BSW_IDLE;
                    drive_low <= 1'b0;
                end
            endcase
        end
    end

    // register updates only at stop, keeping the last byte
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            channel_select <= bsw_pkg::SELECT_RESET;
            channel_enable <= 4'h0;
        end else if (stop_det && pend_valid) begin
            channel_select <= pend;
            channel_enable <= pend[3:0];
        end
    end

    // hold the data line for a while after each clock fall
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_cnt  <= 5'h00;
            sda_out_q <= 1'b1;
        end else if (scl_fall) begin
            // every clock fall restarts the hold window
            hold_cnt <= 5'(HOLD_CYCLES);
        end else if (!hold_done) begin
            // count the window down; the line keeps its level
            hold_cnt <= hold_cnt - 5'h01;
        end else begin
            // window over: follow the wanted level
            sda_out_q <= ~drive_low;
        end
    end

    // open-drain style output: enable low while pulling low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sda_out  <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out  <= 1'b0;
            sda_oe_n <= sda_out_q;
        end
    end
endmodule // bsw_switch_ctrl
`default_nettype wire

// [verification/bsw_i2c_master.sv]
// upstream two-wire controller model: start, stop and byte transfers
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/100ps
`default_nettype none
module bsw_i2c_master (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_rel
);
    // clock low and high times in system clocks; 30/20 gives 400 kHz
    int lo = 30;
    int hi = 20;
    // idle bus: both lines released high
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end
    // wait on falling edges of the system clock
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // a=1 start (data falls, clock high), a=0 stop (data rises)
    task automatic edge_c(input logic a);
        sda_rel = a;
        tk(lo / 2);
        scl = 1'b1;
        tk(hi);
        sda_rel = !a;
        tk(hi);
        scl = !a;
        tk(lo / 2);
    endtask
    // nine clocks, msb first; a 1 in tx releases the line
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_rel = tx[i];
            tk(lo / 2);
            scl = 1'b1;
            tk(hi / 2);
            rx[i] = sda_line;
            tk(hi / 2);
            scl = 1'b0;
            tk(lo / 2);
        end
    endtask
endmodule // bsw_i2c_master
`default_nettype wire

// [verification/bsw_switch_ctrl_props.sv]
// port assertions of the bus switch control logic
// assumes a bind into bsw_switch_ctrl, one clock domain
`timescale 1ns/100ps
`default_nettype none
module bsw_switch_ctrl_props (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       addr_strap_bit_zero,
    input wire logic       addr_strap_bit_one,
    input wire logic       addr_strap_bit_two,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic [3:0] channel_enable,
    input wire logic [7:0] channel_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_reset_clears: assert property (disable iff (1'b0) !rstn |->
        sda_oe_n && channel_enable == 4'h0 && channel_select == 8'h00)
        else $error("outputs not cleared in reset");
    a_release_idle: assert property ($rose(rstn) |-> sda_oe_n)
        else $error("data line driven after reset");
    a_enable_follows: assert property ($changed(channel_select) |=>
        channel_enable == $past(channel_select[3:0]))
        else $error("enable missed new select");
    a_enable_match: assert property ($stable(channel_select) |->
        channel_enable == channel_select[3:0])
        else $error("enable differs from select");
    a_select_at_stop: assert property ($changed(channel_select) |->
        $past(scl_in) && $past(sda_in))
        else $error("select changed outside stop");
    a_hold_after_fall: assert property ($fell(scl_in) |->
        ##1 $stable({sda_oe_n, sda_out}) [*6])
        else $error("data line hold too short");
    a_change_clock_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data line moved with clock high");
    a_drive_low_only: assert property (!sda_oe_n |-> !sda_out)
        else $error("data line driven high");
    c_ack: cover property (!sda_oe_n);
    c_select: cover property ($changed(channel_select));
    c_reset: cover property ($rose(rstn));
endmodule // bsw_switch_ctrl_props
bind bsw_switch_ctrl bsw_switch_ctrl_props u_props (.clk(clk), .rstn(rstn),
    .scl_in(scl_in), .sda_in(sda_in),
    .addr_strap_bit_zero(addr_strap_bit_zero),
    .addr_strap_bit_one(addr_strap_bit_one),
    .addr_strap_bit_two(addr_strap_bit_two), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .channel_enable(channel_enable),
    .channel_select(channel_select));
`default_nettype wire

// [verification/test_bsw_switch_ctrl.sv]
// self-checking bench of the bus switch control logic
// assumes the controller model in bsw_i2c_master.sv
`timescale 1ns/100ps
`default_nettype none
module test_bsw_switch_ctrl;
    logic       clk = 1'b1, rstn = 1'b1;
    logic [2:0] strap = 3'h5;
    logic [8:0] rx;
    int         fail_count = 0, samples_checked = 0, cyc = 0;
    wire        scl, rel, sda_out, oe_n;
    wire  [3:0] en;
    wire  [7:0] sel;
    wire        sda = rel & (oe_n | sda_out); // pulled-up open drain
    wire  [6:0] dev = {bsw_pkg::ADDR_FIXED[3:0], strap};
    bsw_i2c_master u_host (.clk(clk), .sda_line(sda), .scl(scl),
        .sda_rel(rel));
    bsw_switch_ctrl u_dut (.clk(clk), .rstn(rstn), .scl_in(scl),
        .sda_in(sda), .addr_strap_bit_zero(strap[0]),
        .addr_strap_bit_one(strap[1]), .addr_strap_bit_two(strap[2]),
        .sda_out(sda_out), .sda_oe_n(oe_n),
        .channel_enable(en), .channel_select(sel));
    initial forever #25 clk = ~clk;
    // hang guard: a full run takes about 55000 cycles
    always @(posedge clk) if (++cyc == 70000) begin
        fail_count++;
        report_and_stop();
    end
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // addressed write of one byte, stop optional
    task automatic wr(input logic [7:0] d, input logic stop);
        u_host.edge_c(1'b1);
        u_host.xfer({dev, 2'b01}, rx);
        chk("wr ack", 8'(rx[0]), 8'h00);
        u_host.xfer({d, 1'b1}, rx);
        chk("data ack", 8'(rx[0]), 8'h00);
        if (stop) u_host.edge_c(1'b0);
    endtask
    // read back the select register, nack, stop
    task automatic rd(input logic [7:0] d);
        u_host.edge_c(1'b1);
        u_host.xfer({dev, 2'b11}, rx);
        chk("rd ack", 8'(rx[0]), 8'h00);
        u_host.xfer(9'h1ff, rx);
        chk("rd data", rx[8:1], d);
        u_host.edge_c(1'b0);
    endtask
    // every channel combination, upper bits too
    task automatic t_channels();
        for (int i = 0; i < 16; i++) begin
            wr({4'(~i), 4'(i)}, 1'b1);
            chk("sel", sel, {4'(~i), 4'(i)});
            chk("enable", 8'(en), 8'(i));
            rd({4'(~i), 4'(i)});
        end
    endtask
    // two bytes in one write: applied at stop, last one kept
    task automatic t_multi();
        wr(8'h03, 1'b0);
        u_host.xfer({8'h0c, 1'b1}, rx);
        chk("sel pending", sel, 8'h0f);
        u_host.edge_c(1'b0);
        chk("sel last", sel, 8'h0c);
    endtask
    // wrong address ignored; new strap value acknowledged
    task automatic t_addr();
        u_host.edge_c(1'b1);
        u_host.xfer({dev ^ 7'h01, 2'b01}, rx);
        chk("nack", 8'(rx[0]), 8'h01);
        u_host.xfer({8'h0f, 1'b1}, rx);
        u_host.edge_c(1'b0);
        chk("sel kept", sel, 8'h0c);
        for (int s = 0; s < 8; s++) begin
            strap = 3'(s);
            wr({5'h00, 3'(s)}, 1'b1);
            chk("sel strap", sel, {5'h00, 3'(s)});
        end
    endtask
    // standard rate: slow clock, write and read back
    task automatic t_slow();
        u_host.lo = 120;
        u_host.hi = 80;
        wr(8'h0a, 1'b1);
        chk("slow sel", sel, 8'h0a);
        rd(8'h0a);
        u_host.lo = 30;
        u_host.hi = 20;
    endtask
    // reset while the device drives a read bit, then start at once
    task automatic t_reset();
        u_host.edge_c(1'b1);
        u_host.xfer({dev, 2'b11}, rx);
        chk("sda held", 8'(oe_n), 8'h00);
        rstn = 1'b0;
        u_host.tk(10);
        chk("sda free", 8'(oe_n), 8'h01);
        chk("sda out rst", 8'(sda_out), 8'h01);
        chk("sel rst", sel, 8'h00);
        chk("en rst", 8'(en), 8'h00);
        rstn = 1'b1;
        wr(8'h06, 1'b1);
        chk("after rst", sel, 8'h06);
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        @(negedge clk) rstn = 1'b0;
        repeat (20) @(negedge clk);
        chk("sel por", sel, 8'h00);
        rstn = 1'b1;
        t_channels();
        t_multi();
        t_addr();
        t_slow();
        t_reset();
        report_and_stop();
    end
endmodule // test_bsw_switch_ctrl
`default_nettype wire
